// file: core/fault_pkg.sv
`default_nettype none
package fault_pkg;

  // ==========================================================
  // Configuration
  localparam int NUM_CH_DEFAULT = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h000;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h004;
  localparam logic [11:0] FAULT_SUMMARY_OFS = 12'h008;
  localparam logic [11:0] CAUSE_BASE_OFS = 12'h040;
  localparam logic [11:0] CAUSE_STRIDE = 12'h004;
  localparam logic [11:0] STATE_BASE_OFS = 12'h100;
  localparam logic [11:0] STATE_STRIDE = 12'h008;
  localparam logic [11:0] PC_BASE_OFS = 12'h104;
  localparam logic [11:0] PC_STRIDE = 12'h008;

  // ==========================================================
  // Reset values
  localparam logic [31:0] CAUSE_RESET = 32'h00000000;
  localparam logic [31:0] PC_RESET = 32'h00000000;
  localparam logic [31:0] IRQ_RESET = 32'h00000000;

  // ==========================================================
  // Fault cause bit positions
  localparam int LOCKUP_BIT = 31;
  localparam int DBG_INSTR_BIT = 30;
  localparam int DATA_READ_BIT = 18;
  localparam int DATA_WRITE_BIT = 17;
  localparam int INSTR_FETCH_BIT = 16;
  localparam int STORE_UNDERRUN_BIT = 13;
  localparam int BUFFER_ERR_BIT = 12;
  localparam int SEC_ACCESS_BIT = 7;
  localparam int SEC_PERIPH_BIT = 6;
  localparam int SEC_EVENT_BIT = 5;
  localparam int OPERAND_BIT = 1;
  localparam int UNDEF_BIT = 0;

  // ==========================================================
  // Channel state field codes
  localparam logic [3:0] STATE_FAULTING = 4'hF;
  localparam logic [3:0] STATE_FAULT_COMPLETING = 4'hE;

  // ==========================================================
  // Fault report from the execution engine
  typedef struct packed {
    logic lockup;
    logic dbg_instr;
    logic data_read_err;
    logic data_write_err;
    logic instr_fetch_err;
    logic store_underrun_flag;
    logic buffer_err;
    logic secure_access_violation;
    logic secure_peripheral_violation;
    logic secure_event_violation;
    logic operand_invalid;
    logic undef_instr;
  } fault_report_t;

  // Channel view seen by software
  typedef struct packed {
    logic [31:0] cause;
    logic [3:0] state;
    logic [31:0] pc;
  } chan_view_t;

  // Any precise cause present
  function automatic logic report_precise(fault_report_t f);
    return f.instr_fetch_err | f.store_underrun_flag | f.secure_access_violation |
           f.secure_peripheral_violation | f.secure_event_violation | f.operand_invalid | f.undef_instr;
  endfunction

  // Register image of a report; debug source kept only for precise aborts
  function automatic logic [31:0] cause_word(fault_report_t f);
    logic [31:0] w;
    w = 32'h00000000;
    w[LOCKUP_BIT] = f.lockup;
    w[DBG_INSTR_BIT] = f.dbg_instr & report_precise(f);
    w[DATA_READ_BIT] = f.data_read_err;
    w[DATA_WRITE_BIT] = f.data_write_err;
    w[INSTR_FETCH_BIT] = f.instr_fetch_err;
    w[STORE_UNDERRUN_BIT] = f.store_underrun_flag;
    w[BUFFER_ERR_BIT] = f.buffer_err;
    w[SEC_ACCESS_BIT] = f.secure_access_violation;
    w[SEC_PERIPH_BIT] = f.secure_peripheral_violation;
    w[SEC_EVENT_BIT] = f.secure_event_violation;
    w[OPERAND_BIT] = f.operand_invalid;
    w[UNDEF_BIT] = f.undef_instr;
    return w;
  endfunction

endpackage
`default_nettype wire

// file: core/fault_channel_slot.sv
`default_nettype none
module fault_channel_slot (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Execution engine
  input wire logic fault_valid,
  input wire fault_pkg::fault_report_t fault,
  input wire logic restart,
  input wire logic completing,
  input wire logic [3:0] live_state,
  input wire logic [31:0] live_pc,
  // Software view
  output fault_pkg::chan_view_t view,
  output logic faulting,
  output logic fault_event
);
  import fault_pkg::*;

  typedef enum logic {CH_RUN, CH_FAULT} chan_state_t;

  chan_state_t state;
  logic [31:0] cause;
  logic precise;
  logic [31:0] held_pc;
  logic capture;

  // A new fault is taken while running or during a restart; a fault beats a restart
  assign capture = fault_valid & (state == CH_RUN | restart);
  assign faulting = (state == CH_FAULT);
  assign fault_event = capture;

  // Channel state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CH_RUN;
    end else begin
      unique case (state)
        CH_RUN: begin
          if (fault_valid) begin
            state <= CH_FAULT;
          end
        end
        CH_FAULT: begin
          if (restart & ~fault_valid) begin
            state <= CH_RUN;
          end
        end
      endcase
    end
  end

  // Cause capture, held while faulting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause <= CAUSE_RESET;
      precise <= 1'b0;
    end else if (capture) begin
      cause <= cause_word(fault);
      precise <= report_precise(fault);
    end else if (faulting & restart) begin
      cause <= CAUSE_RESET;
      precise <= 1'b0;
    end
  end

  // Faulting instruction address for precise aborts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_pc <= PC_RESET;
    end else if (capture) begin
      held_pc <= live_pc;
    end
  end

  // Software view; imprecise aborts show the live counter
  always_comb begin
    view.cause = cause;
    view.pc = (faulting & precise) ? held_pc : live_pc;
    view.state = live_state;
    if (faulting) begin
      view.state = completing ? STATE_FAULT_COMPLETING : STATE_FAULTING;
    end
  end

  property p_capture;
    @(posedge clk) disable iff (!rst_n)
    (fault_valid && !faulting) |=> (faulting && cause == cause_word($past(fault)));
  endproperty
  a_capture: assert property (p_capture) else $error("fault cause not captured");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    (faulting && !restart) |=> (faulting && $stable(cause));
  endproperty
  a_hold: assert property (p_hold) else $error("fault cause changed while faulting");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    (faulting && restart && !fault_valid) |=> (!faulting && cause == 32'h00000000);
  endproperty
  a_clear: assert property (p_clear) else $error("restart did not clear cause");

  property p_precise_pc;
    @(posedge clk) disable iff (!rst_n)
    (capture && report_precise(fault)) |=> (view.pc == $past(live_pc));
  endproperty
  a_precise_pc: assert property (p_precise_pc) else $error("faulting address lost");

  property p_precise_hold;
    @(posedge clk) disable iff (!rst_n)
    (faulting && precise && !restart) |=> $stable(view.pc);
  endproperty
  a_precise_hold: assert property (p_precise_hold) else $error("faulting address moved");

  property p_state_code;
    @(posedge clk) disable iff (!rst_n)
    faulting |-> (view.state == (completing ? 4'hE : 4'hF));
  endproperty
  a_state_code: assert property (p_state_code) else $error("wrong faulting state code");

  property p_lockup;
    @(posedge clk) disable iff (!rst_n)
    (fault_valid && !faulting && fault.lockup) |=> cause[31];
  endproperty
  a_lockup: assert property (p_lockup) else $error("lockup bit not set");

  property p_dbg_imprecise;
    @(posedge clk) disable iff (!rst_n)
    (fault_valid && !faulting && !report_precise(fault)) |=> (!cause[30] && view.pc == live_pc);
  endproperty
  a_dbg_imprecise: assert property (p_dbg_imprecise) else $error("imprecise abort handled as precise");

  property p_bus_err;
    @(posedge clk) disable iff (!rst_n)
    (fault_valid && !faulting) |=> (cause[18:16] == {$past(fault.data_read_err), $past(fault.data_write_err),
                                     $past(fault.instr_fetch_err)});
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error bits wrong");

endmodule
`default_nettype wire

// file: core/dma_channel_fault_type_capture.sv
`default_nettype none
module dma_channel_fault_type_capture #(
  parameter int NUM_CH = fault_pkg::NUM_CH_DEFAULT
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [fault_pkg::ADDR_W-1:0] PADDR,
  input wire logic [fault_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [fault_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Execution engine, one entry per channel
  input wire logic [NUM_CH-1:0] FAULT_VALID,
  input wire fault_pkg::fault_report_t [NUM_CH-1:0] FAULT_CAUSE,
  input wire logic [NUM_CH-1:0] CH_RESTART,
  input wire logic [NUM_CH-1:0] CH_COMPLETING,
  input wire logic [NUM_CH-1:0][3:0] CH_STATE,
  input wire logic [NUM_CH-1:0][31:0] CH_PC,
  // Interrupt
  output logic IRQ
);
  import fault_pkg::*;

  // ==========================================================
  // Channel slots
  chan_view_t view [NUM_CH];
  logic [NUM_CH-1:0] faulting;
  logic [NUM_CH-1:0] fault_event;

  // One slot per channel
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    fault_channel_slot u_slot (
      .clk(CLK),
      .rst_n(RSTN),
      .fault_valid(FAULT_VALID[g]),
      .fault(FAULT_CAUSE[g]),
      .restart(CH_RESTART[g]),
      .completing(CH_COMPLETING[g]),
      .live_state(CH_STATE[g]),
      .live_pc(CH_PC[g]),
      .view(view[g]),
      .faulting(faulting[g]),
      .fault_event(fault_event[g])
    );
  end

  // ==========================================================
  // APB handshake
  logic access;
  logic wr_fire;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;

  // One wait state: ready follows the first access cycle
  assign access = PSEL & PENABLE & ~PREADY;
  assign wr_fire = PSEL & PENABLE & PREADY & PWRITE;

  // Byte-lane merge of write data into a register
  function automatic logic [31:0] lane_merge(logic [31:0] old, logic [31:0] wd, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Address match of a per-channel register
  function automatic logic chan_hit(logic [11:0] addr, logic [11:0] base, logic [11:0] stride, int idx);
    return addr == 12'(base + stride * 12'(idx));
  endfunction

  // Read decode; unmapped addresses flag an error
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b0;
    if (PADDR == IRQ_STATUS_OFS) begin
      rd_word = irq_status;
      rd_hit = 1'b1;
    end else if (PADDR == IRQ_MASK_OFS) begin
      rd_word = irq_mask;
      rd_hit = 1'b1;
    end else if (PADDR == FAULT_SUMMARY_OFS) begin
      rd_word = 32'(faulting);
      rd_hit = 1'b1;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (chan_hit(PADDR, CAUSE_BASE_OFS, CAUSE_STRIDE, i)) begin
        rd_word = view[i].cause;
        rd_hit = 1'b1;
      end
      if (chan_hit(PADDR, STATE_BASE_OFS, STATE_STRIDE, i)) begin
        rd_word = {28'h0000000, view[i].state};
        rd_hit = 1'b1;
      end
      if (chan_hit(PADDR, PC_BASE_OFS, PC_STRIDE, i)) begin
        rd_word = view[i].pc;
        rd_hit = 1'b1;
      end
    end
  end

  // Registered answer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access;
      PSLVERR <= access & ~rd_hit;
      if (access & ~PWRITE) begin
        PRDATA <= rd_word;
      end else begin
        PRDATA <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // Interrupt status and mask
  logic [31:0] next_irq_status;
  logic [31:0] w1c;
  logic [31:0] events;

  assign events = 32'(fault_event);
  assign w1c = (wr_fire && PADDR == IRQ_STATUS_OFS) ? lane_merge(32'h00000000, PWDATA, PSTRB) : 32'h00000000;
  // New events win over a clear in the same cycle
  assign next_irq_status = (irq_status & ~w1c) | events;

  // Sticky status
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Mask, one bit per channel
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_mask <= IRQ_RESET;
    end else if (wr_fire && PADDR == IRQ_MASK_OFS) begin
      irq_mask <= lane_merge(irq_mask, PWDATA, PSTRB) & 32'((64'h1 << NUM_CH) - 64'h1);
    end
  end

  // Level interrupt
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_irq_status & irq_mask);
    end
  end

  // ==========================================================
  // Checks
  property p_ready;
    @(posedge CLK) disable iff (!RSTN)
    (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("APB answer not one wait state");

  property p_ro;
    @(posedge CLK) disable iff (!RSTN)
    (wr_fire && PADDR == CAUSE_BASE_OFS && !FAULT_VALID[0] && !CH_RESTART[0]) |=> $stable(view[0].cause);
  endproperty
  a_ro: assert property (p_ro) else $error("write changed cause register");

  property p_irq_set;
    @(posedge CLK) disable iff (!RSTN)
    (fault_event[0] && irq_mask[0]) |=> (irq_status[0] && IRQ);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("fault did not raise interrupt");

  property p_set_wins;
    @(posedge CLK) disable iff (!RSTN)
    (fault_event[0] && w1c[0]) |=> irq_status[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_reserved;
    @(posedge CLK) disable iff (!RSTN)
    (access && !PWRITE && PADDR == CAUSE_BASE_OFS) |=> (PRDATA[29:19] == 11'h000 && PRDATA[15:14] == 2'h0 &&
                                                        PRDATA[11:8] == 4'h0 && PRDATA[4:2] == 3'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved cause bits nonzero");

  property p_err;
    @(posedge CLK) disable iff (!RSTN)
    access |=> (PSLVERR == !$past(rd_hit));
  endproperty
  a_err: assert property (p_err) else $error("error response does not match decode");

  property p_wr_zero;
    @(posedge CLK) disable iff (!RSTN)
    (access && PWRITE) |=> (PRDATA == 32'h00000000);
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data driven on a write");

  property p_idle_quiet;
    @(posedge CLK) disable iff (!RSTN)
    !access |=> (!PREADY && !PSLVERR && PRDATA == 32'h00000000);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer outside a transfer");

  property p_summary;
    @(posedge CLK) disable iff (!RSTN)
    (access && !PWRITE && PADDR == FAULT_SUMMARY_OFS) |=> (PRDATA == 32'($past(faulting)));
  endproperty
  a_summary: assert property (p_summary) else $error("faulting summary wrong");

  property p_mask_upper;
    @(posedge CLK) disable iff (!RSTN)
    (irq_mask >> NUM_CH) == 32'h00000000;
  endproperty
  a_mask_upper: assert property (p_mask_upper) else $error("mask bit above channel count set");

  property p_irq_hold;
    @(posedge CLK) disable iff (!RSTN)
    (irq_status[0] && irq_mask[0] && !w1c[0]) |=> IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped while pending");

  // ==========================================================
  // Per-channel cause bit and live state checks
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
    property p_dbg_bit;
      @(posedge CLK) disable iff (!RSTN)
      (FAULT_VALID[c] && !faulting[c] && FAULT_CAUSE[c].dbg_instr && report_precise(FAULT_CAUSE[c])) |=>
        view[c].cause[DBG_INSTR_BIT];
    endproperty
    a_dbg_bit: assert property (p_dbg_bit) else $error("debug source bit not set");

    property p_underrun_bit;
      @(posedge CLK) disable iff (!RSTN)
      (FAULT_VALID[c] && !faulting[c] && FAULT_CAUSE[c].store_underrun_flag) |=> view[c].cause[STORE_UNDERRUN_BIT];
    endproperty
    a_underrun_bit: assert property (p_underrun_bit) else $error("store underrun bit not set");

    property p_buffer_bit;
      @(posedge CLK) disable iff (!RSTN)
      (FAULT_VALID[c] && !faulting[c] && FAULT_CAUSE[c].buffer_err) |=> view[c].cause[BUFFER_ERR_BIT];
    endproperty
    a_buffer_bit: assert property (p_buffer_bit) else $error("buffer bit not set");

    property p_sec_access_bit;
      @(posedge CLK) disable iff (!RSTN)
      (FAULT_VALID[c] && !faulting[c] && FAULT_CAUSE[c].secure_access_violation) |=> view[c].cause[SEC_ACCESS_BIT];
    endproperty
    a_sec_access_bit: assert property (p_sec_access_bit) else $error("secure access bit not set");

    property p_sec_periph_bit;
      @(posedge CLK) disable iff (!RSTN)
      (FAULT_VALID[c] && !faulting[c] && FAULT_CAUSE[c].secure_peripheral_violation) |=>
        view[c].cause[SEC_PERIPH_BIT];
    endproperty
    a_sec_periph_bit: assert property (p_sec_periph_bit) else $error("secure peripheral bit not set");

    property p_sec_event_bit;
      @(posedge CLK) disable iff (!RSTN)
      (FAULT_VALID[c] && !faulting[c] && FAULT_CAUSE[c].secure_event_violation) |=> view[c].cause[SEC_EVENT_BIT];
    endproperty
    a_sec_event_bit: assert property (p_sec_event_bit) else $error("secure event bit not set");

    property p_operand_bit;
      @(posedge CLK) disable iff (!RSTN)
      (FAULT_VALID[c] && !faulting[c] && FAULT_CAUSE[c].operand_invalid) |=> view[c].cause[OPERAND_BIT];
    endproperty
    a_operand_bit: assert property (p_operand_bit) else $error("operand bit not set");

    property p_undef_bit;
      @(posedge CLK) disable iff (!RSTN)
      (FAULT_VALID[c] && !faulting[c] && FAULT_CAUSE[c].undef_instr) |=> view[c].cause[UNDEF_BIT];
    endproperty
    a_undef_bit: assert property (p_undef_bit) else $error("undefined instruction bit not set");

    property p_state_live;
      @(posedge CLK) disable iff (!RSTN)
      !faulting[c] |-> (view[c].state == CH_STATE[c]);
    endproperty
    a_state_live: assert property (p_state_live) else $error("live state not passed through");
  end

endmodule
`default_nettype wire

// file: sim/fault_engine_model.sv
`default_nettype none
module fault_engine_model #(
  parameter int NUM_CH = 4
) (
  // Clock
  input wire logic clk,
  // Fault reports and channel status toward the capture block
  output logic [NUM_CH-1:0] fault_valid,
  output fault_pkg::fault_report_t [NUM_CH-1:0] fault_cause,
  output logic [NUM_CH-1:0] restart,
  output logic [NUM_CH-1:0] completing,
  output logic [NUM_CH-1:0][3:0] state,
  output logic [NUM_CH-1:0][31:0] pc
);
  timeunit 1ns;
  timeprecision 1ps;
  import fault_pkg::*;

  // ==========================================================
  // Idle values: every channel running
  initial begin
    fault_valid = '0;
    fault_cause = '0;
    restart = '0;
    completing = '0;
    state = {NUM_CH{4'h1}};
    pc = '0;
  end

  // One-cycle report; the program counter moves on right after it
  task automatic inject(input int ch, input fault_report_t f, input logic [31:0] at_pc);
    @(posedge clk);
    fault_valid[ch] <= 1'b1;
    fault_cause[ch] <= f;
    pc[ch] <= at_pc;
    @(posedge clk);
    fault_valid[ch] <= 1'b0;
    fault_cause[ch] <= ~f; // Stale report must not look valid
    pc[ch] <= at_pc + 32'h4;
  endtask

  // Restart pulse leaves the faulting state
  task automatic do_restart(input int ch);
    @(posedge clk);
    restart[ch] <= 1'b1;
    @(posedge clk);
    restart[ch] <= 1'b0;
  endtask

  // Outstanding transfers still draining
  task automatic set_completing(input int ch, input logic v);
    @(posedge clk);
    completing[ch] <= v;
  endtask
endmodule
`default_nettype wire

// file: sim/dma_channel_fault_type_capture_tb.sv
`default_nettype none
module dma_channel_fault_type_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fault_pkg::*;

  // ==========================================================
  // Signals
  localparam int NCH = 4;
  logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0] PSTRB;
  logic er;
  logic [NCH-1:0] FAULT_VALID, CH_RESTART, CH_COMPLETING;
  fault_report_t [NCH-1:0] FAULT_CAUSE;
  logic [NCH-1:0][3:0] CH_STATE;
  logic [NCH-1:0][31:0] CH_PC;
  int n_fail = 0;
  int samples_checked = 0;
  integer seed = 32'he1f1;
  int pos[12] = '{31, 30, 18, 17, 16, 13, 12, 7, 6, 5, 1, 0};

  dma_channel_fault_type_capture #(.NUM_CH(NCH)) dut (
    .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FAULT_VALID(FAULT_VALID), .FAULT_CAUSE(FAULT_CAUSE), .CH_RESTART(CH_RESTART),
    .CH_COMPLETING(CH_COMPLETING), .CH_STATE(CH_STATE), .CH_PC(CH_PC), .IRQ(IRQ)
  );

  fault_engine_model #(.NUM_CH(NCH)) eng (
    .clk(CLK), .fault_valid(FAULT_VALID), .fault_cause(FAULT_CAUSE), .restart(CH_RESTART),
    .completing(CH_COMPLETING), .state(CH_STATE), .pc(CH_PC)
  );

  // ==========================================================
  // Clock and watchdog
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    final_report();
  end

  // ==========================================================
  // Reference model and helpers
  function automatic logic [31:0] exp_word(input logic [11:0] f);
    logic [31:0] w;
    w = 32'h00000000;
    for (int j = 0; j < 12; j++) w[pos[j]] = f[11-j];
    w[30] = f[10] & (|(f & 12'h0DF)); // Debug source only beside a precise cause
    return w;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // APB transfer held until PREADY is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    check("pready", {31'h0, PREADY}, 32'h1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, er);
    check(nm, rd, e);
    check({nm, "_err"}, {31'h0, er}, 32'h0);
  endtask

  // Full fault cycle on one channel: capture, views, interrupt, restart
  task automatic fault_case(input int ch, input logic [11:0] f);
    logic [31:0] pc;
    logic prec;
    pc = $random(seed);
    prec = |(f & 12'h0DF);
    eng.inject(ch, f, pc);
    rchk("cause", CAUSE_BASE_OFS + 12'(4 * ch), exp_word(f));
    rchk("state", STATE_BASE_OFS + 12'(8 * ch), {28'h0, STATE_FAULTING});
    rchk("pc", PC_BASE_OFS + 12'(8 * ch), prec ? pc : pc + 32'h4);
    rchk("summary", FAULT_SUMMARY_OFS, 32'h1 << ch);
    rchk("status", IRQ_STATUS_OFS, 32'h1 << ch);
    check("irq", {31'h0, IRQ}, 32'h1);
    apb(1'b1, IRQ_STATUS_OFS, 32'h1 << ch, rd, er);
    @(posedge CLK);
    check("irq_clr", {31'h0, IRQ}, 32'h0);
    eng.do_restart(ch);
    rchk("cause_clr", CAUSE_BASE_OFS + 12'(4 * ch), 32'h0);
    rchk("state_live", STATE_BASE_OFS + 12'(8 * ch), 32'h1);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    RSTN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h00000000;
    PSTRB = 4'hF;
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    // Reset values, read-only and unmapped places
    rchk("cause_rst", CAUSE_BASE_OFS + 12'hC, CAUSE_RESET);
    rchk("status_rst", IRQ_STATUS_OFS, IRQ_RESET);
    apb(1'b1, CAUSE_BASE_OFS, 32'hFFFFFFFF, rd, er);
    rchk("cause_ro", CAUSE_BASE_OFS, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0, rd, er);
    check("unmapped_err", {31'h0, er}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b1, IRQ_MASK_OFS, 32'hFFFFFFFF, rd, er);
    rchk("mask", IRQ_MASK_OFS, 32'h0000000F);
    // No byte lanes enabled: the mask must not change
    PSTRB <= 4'h0;
    apb(1'b1, IRQ_MASK_OFS, 32'h0, rd, er);
    PSTRB <= 4'hF;
    rchk("mask_strb", IRQ_MASK_OFS, 32'h0000000F);
    // Every cause bit alone, spread over the channels
    for (int j = 0; j < 12; j++) begin
      fault_case(j % NCH, 12'h800 >> j);
    end
    fault_case(2, 12'h401);
    // Later fault ignored while faulting; masked interrupt; completing code
    apb(1'b1, IRQ_MASK_OFS, 32'h0, rd, er);
    eng.inject(1, 12'h800, 32'h100);
    eng.inject(1, 12'h001, 32'h200);
    rchk("cause_hold", CAUSE_BASE_OFS + 12'h4, 32'h80000000);
    check("irq_masked", {31'h0, IRQ}, 32'h0);
    eng.set_completing(1, 1'b1);
    rchk("state_comp", STATE_BASE_OFS + 12'h8, {28'h0, STATE_FAULT_COMPLETING});
    eng.set_completing(1, 1'b0);
    apb(1'b1, IRQ_STATUS_OFS, 32'hF, rd, er);
    apb(1'b1, IRQ_MASK_OFS, 32'hF, rd, er);
    eng.do_restart(1);
    // Random reports, several causes at once
    repeat (10) begin
      fault_case(int'($unsigned($random(seed)) % NCH), 12'($random(seed)));
    end
    final_report();
  end
endmodule
`default_nettype wire
